/* File: src/cxa_exec.sv */
/*
 * Group-A instruction executor: decodes one 14-bit instruction per
 * instruction cycle, drives accumulator, flags, file write, stack push,
 * program counter load, watchdog clear and skip of the next instruction.
 * Assumes the file memory returns file_rdata combinationally for
 * file_addr, the stack stores stack_head on push, and the watchdog
 * counter clears on wdt_clear. instr must hold for the whole cycle.
 */
`timescale 1ns/10ps
module cxa_exec (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // instruction in
   input wire logic [13:0] instr,
   input wire logic [12:0] pc_next_seq,
   input wire logic [7:0] pc_high_latch,
   // file register port
   input wire logic [7:0] file_rdata,
   output logic [6:0] file_addr,
   output logic [7:0] file_wdata,
   output logic file_we,
   // core state
   output logic [7:0] acc,
   output logic zero_flag,
   output logic carry_flag,
   output logic nibble_overflow_bit,
   output logic watchdog_expiry_flag,
   output logic sleep_flag,
   // control flow
   output logic [12:0] program_counter,
   output logic pc_load,
   output logic [12:0] stack_head,
   output logic stack_push,
   output logic wdt_clear,
   output logic discard_next,
   output logic cycle_end
);
   // phase inside an instruction cycle, last phase commits
   logic [1:0] phase;
   logic nop_slot;
   wire logic commit;
   assign commit = (phase == cxa_pkg::PHASE_LAST);

   // decode
   wire logic [5:0] opc6;
   wire logic add_lit, and_lit, add_file, and_file, clr_any, clr_file;
   wire logic clr_acc, dec_file, inv_file, dec_skip, bit_skip, call_op;
   wire logic wdt_op, to_file, file_op;
   wire logic [2:0] bit_sel;
   wire logic [6:0] faddr;
   assign opc6 = instr[13:8];
   assign add_lit = (instr[13:9] == cxa_pkg::OPC_ADD_LIT);
   assign and_lit = (opc6 == cxa_pkg::OPC_AND_LIT);
   assign add_file = (opc6 == cxa_pkg::OPC_ADD_FILE);
   assign and_file = (opc6 == cxa_pkg::OPC_AND_FILE);
   assign clr_any = (opc6 == cxa_pkg::OPC_CLR);
   assign clr_file = clr_any & instr[cxa_pkg::DEST_BIT];
   // low seven bits are ignored for the acc clear
   assign clr_acc = clr_any & ~instr[cxa_pkg::DEST_BIT];
   assign dec_file = (opc6 == cxa_pkg::OPC_DEC_FILE);
   assign inv_file = (opc6 == cxa_pkg::OPC_INV_FILE);
   assign dec_skip = (opc6 == cxa_pkg::OPC_DEC_SKIP);
   assign bit_skip = (instr[13:10] == cxa_pkg::OPC_BIT_SKIP);
   assign call_op = (instr[13:11] == cxa_pkg::OPC_CALL);
   assign wdt_op = (instr == cxa_pkg::OPC_WDT_RESET);
   assign faddr = instr[cxa_pkg::FILE_HI:0];
   assign bit_sel = instr[cxa_pkg::BIT_LO+2:cxa_pkg::BIT_LO];
   assign to_file = instr[cxa_pkg::DEST_BIT];
   assign file_op = add_file | and_file | dec_file | inv_file | dec_skip;

   // operand and operation select
   wire logic [7:0] opnd, res;
   wire logic [2:0] sel;
   wire logic c_out, dc_out, z_out;
   assign opnd = (add_lit | and_lit) ? instr[7:0] : file_rdata;
   assign sel = (add_lit | add_file) ? 3'h0 :
                (and_lit | and_file) ? 3'h1 :
                (dec_file | dec_skip) ? 3'h2 :
                inv_file ? 3'h3 : 3'h4;
   cxa_alu u_alu (
      .acc(acc),
      .opnd(opnd),
      .sel(sel),
      .res(res),
      .carry(c_out),
      .nibble_carry(dc_out),
      .is_zero(z_out)
   );

   // effects of the current instruction, valid in the commit phase
   wire logic live, acc_we, fwe, z_we, c_we, skip_now, bit_hit;
   wire logic [7:0] next_acc, next_fdata;
   wire logic [12:0] next_pc;
   assign live = commit & ~nop_slot;
   assign bit_hit = file_rdata[bit_sel];
   assign acc_we = live & (add_lit | and_lit | clr_acc |
                   (file_op & ~to_file));
   assign fwe = live & ((file_op & to_file) | clr_file);
   assign next_acc = clr_acc ? 8'h00 : res;
   assign next_fdata = clr_file ? 8'h00 : res;
   // decrement skip touches no flag
   assign z_we = live & (add_lit | and_lit | add_file | and_file |
                 dec_file | inv_file | clr_any);
   assign c_we = live & (add_lit | add_file);
   assign skip_now = live & ((bit_skip & bit_hit) |
                     (dec_skip & z_out));
   // pc high bits from latch bits 4:3
   assign next_pc = {pc_high_latch[4:3], instr[10:0]};

   // phase counter and slot after a skip or call runs as a no-op
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         phase <= 2'h0;
         nop_slot <= 1'b0;
      end else begin
         phase <= phase + 2'h1;
         if (commit) begin
            nop_slot <= skip_now | (live & call_op);
         end
      end
   end

   // accumulator and status flags
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         acc <= cxa_pkg::ACC_RESET;
         zero_flag <= 1'b0;
         carry_flag <= 1'b0;
         nibble_overflow_bit <= 1'b0;
         watchdog_expiry_flag <= 1'b1;
         sleep_flag <= 1'b1;
      end else begin
         if (acc_we) begin
            acc <= next_acc;
         end
         if (z_we) begin
            zero_flag <= clr_any | z_out;
         end
         if (c_we) begin
            carry_flag <= c_out;
            nibble_overflow_bit <= dc_out;
         end
         if (live & wdt_op) begin
            watchdog_expiry_flag <= 1'b1;
            sleep_flag <= 1'b1;
         end
      end
   end

   // one-cycle strobes toward memory, stack, watchdog and fetch
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         file_addr <= 7'h00;
         file_wdata <= 8'h00;
         file_we <= 1'b0;
         stack_head <= cxa_pkg::PC_RESET;
         stack_push <= 1'b0;
         program_counter <= cxa_pkg::PC_RESET;
         pc_load <= 1'b0;
         wdt_clear <= 1'b0;
         discard_next <= 1'b0;
         cycle_end <= 1'b0;
      end else begin
         file_addr <= faddr;
         file_wdata <= next_fdata;
         file_we <= fwe;
         stack_push <= live & call_op; // push in the same cycle as pc load
         if (live & call_op) begin
            stack_head <= pc_next_seq;
            program_counter <= next_pc;
         end
         pc_load <= live & call_op;
         wdt_clear <= live & wdt_op; // counter and prescaler
         discard_next <= skip_now;
         cycle_end <= commit;
      end
   end
endmodule : cxa_exec

/* File: src/cxa_pkg.sv */
/*
 * Package for the group-A instruction executor: opcode patterns, field
 * positions, accumulator and program counter reset values and instruction-cycle timing.
 * Assumes a 14-bit instruction word and an 8-bit data path.
 */
// Notes on behaviour
// - literal add: acc plus literal, C DC Z
// - literal and: acc and literal, Z only
// - destination bit 0 to acc, 1 to file
// - file add: acc plus file, C DC Z
// - file and: acc and file, Z
// - bit set skips next, two cycles
// - call pushes pc plus one, loads k
// - call fills pc 12:11 from latch 4:3
// - clear file writes zero, sets Z
// - clear acc loads zero, sets Z
// - watchdog reset clears counter, sets flags
// - decrement file to destination, updates Z
// - invert file to destination, updates Z
// - decrement skip leaves flags unchanged
// - zero decrement result skips, two cycles
// - one instruction cycle is four clocks
// - file address range 00 to 7F
package cxa_pkg;
   // instruction cycle length in clock periods
   localparam int CYC_PHASES = 4;
   localparam logic [1:0] PHASE_LAST = 2'h3;
   // instruction field positions
   localparam int DEST_BIT = 7;
   localparam int BIT_LO = 7;
   localparam int FILE_HI = 6;
   localparam logic [6:0] FILE_MAX = 7'h7F;
   // opcode patterns, compared on bits 13:8, 13:9, 13:10, 13:11 or the whole word
   localparam logic [5:0] OPC_ADD_FILE = 6'h07;
   localparam logic [5:0] OPC_AND_FILE = 6'h05;
   localparam logic [5:0] OPC_CLR = 6'h01;
   localparam logic [5:0] OPC_DEC_FILE = 6'h03;
   localparam logic [5:0] OPC_INV_FILE = 6'h09;
   localparam logic [5:0] OPC_DEC_SKIP = 6'h0B;
   localparam logic [5:0] OPC_AND_LIT = 6'h39;
   localparam logic [4:0] OPC_ADD_LIT = 5'h1F;
   localparam logic [3:0] OPC_BIT_SKIP = 4'h7;
   localparam logic [2:0] OPC_CALL = 3'h4;
   localparam logic [13:0] OPC_WDT_RESET = 14'h0064;
   // reset values
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [12:0] PC_RESET = 13'h0000;
   typedef enum logic [1:0] {
      CXA_OP_NONE = 2'b00,
      CXA_OP_ADD = 2'b01,
      CXA_OP_AND = 2'b10,
      CXA_OP_OTHER = 2'b11
   } cxa_alu_t;
endpackage : cxa_pkg

/* File: src/cxa_alu.sv */
/*
 * Eight-bit arithmetic core for the group-A executor: sum with carry and
 * digit carry, and, invert, decrement, plus zero detect.
 * Assumes operand selection is done by the caller; purely combinational.
 */
`timescale 1ns/10ps
module cxa_alu (
   // operands and operation
   input wire logic [7:0] acc,
   input wire logic [7:0] opnd,
   input wire logic [2:0] sel,
   // results
   output logic [7:0] res,
   output logic carry,
   output logic nibble_carry,
   output logic is_zero
);
   wire logic [8:0] sum_full;
   wire logic [4:0] sum_low;
   // sel: 0 add, 1 and, 2 dec, 3 invert, others zero
   assign sum_full = {1'b0, acc} + {1'b0, opnd};
   assign sum_low = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
   assign res = (sel == 3'h0) ? sum_full[7:0] :
                (sel == 3'h1) ? (acc & opnd) :
                (sel == 3'h2) ? (opnd - 8'h01) :
                (sel == 3'h3) ? ~opnd : 8'h00;
   assign carry = sum_full[8];
   assign nibble_carry = sum_low[4];
   assign is_zero = (res == 8'h00);
endmodule : cxa_alu

/* File: test/cxa_exec_props.sv */
/* checker for cxa_exec: timing of the commit pulses and results.
   assumes one clock domain and the port names of cxa_exec. */
`timescale 1ns/10ps
module cxa_exec_props (
   // clock, reset and inputs
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [13:0] instr,
   input wire logic [12:0] pc_next_seq,
   input wire logic [7:0] pc_high_latch,
   // state and pulses
   input wire logic [6:0] file_addr,
   input wire logic [7:0] file_wdata,
   input wire logic file_we,
   input wire logic [7:0] acc,
   input wire logic zero_flag,
   input wire logic carry_flag,
   input wire logic watchdog_expiry_flag,
   input wire logic sleep_flag,
   input wire logic [12:0] program_counter,
   input wire logic pc_load,
   input wire logic [12:0] stack_head,
   input wire logic stack_push,
   input wire logic wdt_clear,
   input wire logic discard_next,
   input wire logic cycle_end
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // slots are four clocks; pulses only mark a commit
   property p_cyc;
      cycle_end |=> !cycle_end [*3] ##1 cycle_end;
   endproperty
   a_cyc: assert property (p_cyc) else $error("slot length wrong");
   property p_pulse;
      file_we || pc_load || wdt_clear || discard_next |-> cycle_end;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse off slot");
   // call target and return address
   property p_call;
      pc_load |-> stack_push && stack_head == $past(pc_next_seq) &&
         program_counter == {$past(pc_high_latch[4:3]), $past(instr[10:0])};
   endproperty
   a_call: assert property (p_call) else $error("call wrong");
   // the slot after a skip or call must do nothing
   property p_nop;
      discard_next || pc_load |-> ##4 (!file_we && !pc_load && $stable(acc));
   endproperty
   a_nop: assert property (p_nop) else $error("nop slot acted");
   property p_wdt;
      wdt_clear |-> watchdog_expiry_flag && sleep_flag &&
         $past(instr) == cxa_pkg::OPC_WDT_RESET;
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog clear wrong");
   // decrement-skip keeps its flags, so it is left out here
   property p_zero;
      file_we && $past(instr[13:8]) != cxa_pkg::OPC_DEC_SKIP |->
         zero_flag == (file_wdata == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   property p_addr;
      file_we |-> file_addr == $past(instr[6:0]) && $past(instr[7]);
   endproperty
   a_addr: assert property (p_addr) else $error("file write wrong");
   property p_add;
      cycle_end && !$past(discard_next, 4) && !$past(pc_load, 4) &&
         $past(instr[13:9]) == cxa_pkg::OPC_ADD_LIT |->
         {carry_flag, acc} == $past(acc) + $past(instr[7:0]);
   endproperty
   a_add: assert property (p_add) else $error("literal add wrong");
   c_call: cover property (pc_load);
   c_skip: cover property (discard_next);
   c_wr: cover property (file_we);
endmodule : cxa_exec_props
bind cxa_exec cxa_exec_props i_cxa_exec_props (.*);

/* File: test/test_cxa_exec.sv */
/* bench for cxa_exec: instruction sequences with expected results.
   assumes file memory is played by the bench through file_rdata. */
`timescale 1ns/10ps
module test_cxa_exec;
   logic clk_sys, resetn, file_we, zero_flag, carry_flag;
   logic nibble_overflow_bit, watchdog_expiry_flag, sleep_flag, pc_load;
   logic stack_push, wdt_clear, discard_next, cycle_end;
   logic [13:0] instr;
   logic [12:0] pc_next_seq, program_counter, stack_head;
   logic [7:0] pc_high_latch, file_rdata, file_wdata, acc;
   logic [6:0] file_addr;
   int fail_count, compares;
   cxa_exec i_cxa_exec (.*);
   task chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task tally_and_finish;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish
   // one slot: present at phase 1, look just after the commit edge
   task run(input logic [13:0] i, input logic [7:0] r, input logic [7:0] ea,
         input logic [2:0] f, input logic [1:0] wd, input logic [7:0] ew);
      @(posedge clk_sys);
      instr <= i;
      file_rdata <= r;
      repeat (3) @(posedge clk_sys);
      #1;
      chk(acc, ea);
      chk({zero_flag, carry_flag, nibble_overflow_bit}, f);
      chk({file_we, discard_next, cycle_end}, {wd, 1'b1});
      if (wd[1]) chk({file_addr, file_wdata}, {i[6:0], ew});
   endtask : run
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // hang guard
   initial begin
      #200000;
      fail_count++;
      tally_and_finish();
   end
   initial begin
      resetn = 1'b0;
      instr = 14'h0000;
      file_rdata = 8'h00;
      pc_next_seq = 13'h0123;
      pc_high_latch = 8'h17;
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      #1;
      chk({acc, watchdog_expiry_flag, sleep_flag}, {8'h00, 2'h3});
      run(14'h3E8F, 8'h00, 8'h8F, 3'h0, 2'h0, 8'h00);
      run(14'h3F71, 8'h00, 8'h00, 3'h7, 2'h0, 8'h00);
      run(14'h077F, 8'hA3, 8'hA3, 3'h0, 2'h0, 8'h00);
      run(14'h0585, 8'h5F, 8'hA3, 3'h0, 2'h2, 8'h03);
      run(14'h07FF, 8'h5D, 8'hA3, 3'h7, 2'h2, 8'h00);
      run(14'h395F, 8'h00, 8'h03, 3'h3, 2'h0, 8'h00);
      run(14'h0390, 8'h01, 8'h03, 3'h7, 2'h2, 8'h00);
      run(14'h0913, 8'h13, 8'hEC, 3'h3, 2'h0, 8'h00);
      run(14'h0B13, 8'h01, 8'h00, 3'h3, 2'h1, 8'h00);
      run(14'h3E01, 8'h00, 8'h00, 3'h3, 2'h0, 8'h00);
      run(14'h0BA2, 8'h05, 8'h00, 3'h3, 2'h2, 8'h04);
      run(14'h1FC0, 8'h80, 8'h00, 3'h3, 2'h1, 8'h00);
      run(14'h3E01, 8'h00, 8'h00, 3'h3, 2'h0, 8'h00);
      run(14'h1C40, 8'hFE, 8'h00, 3'h3, 2'h0, 8'h00);
      run(14'h3E0F, 8'h00, 8'h0F, 3'h0, 2'h0, 8'h00);
      run(14'h3E01, 8'h00, 8'h10, 3'h1, 2'h0, 8'h00);
      run(14'h017F, 8'h00, 8'h00, 3'h5, 2'h0, 8'h00);
      run(14'h3E05, 8'h00, 8'h05, 3'h0, 2'h0, 8'h00);
      run(14'h01A0, 8'h77, 8'h05, 3'h4, 2'h2, 8'h00);
      run(14'h22AA, 8'h00, 8'h05, 3'h4, 2'h0, 8'h00);
      chk({pc_load, stack_push, program_counter}, 15'h72AA);
      chk(stack_head, 13'h0123);
      run(14'h3E01, 8'h00, 8'h05, 3'h4, 2'h0, 8'h00);
      chk(pc_load, 1'b0);
      run(14'h0064, 8'h00, 8'h05, 3'h4, 2'h0, 8'h00);
      chk({wdt_clear, watchdog_expiry_flag, sleep_flag}, 3'h7);
      tally_and_finish();
   end
endmodule : test_cxa_exec
